// ---- qsr_pkg.sv ----
/*
  Package for the egress QoS scheduler and rate control block.
  Assumes a single APB clock domain and 32-bit APB data.
*/
package qsr_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL        = 12'h000;
  localparam logic [11:0] OFS_DROP_RATE_A = 12'h004;
  localparam logic [11:0] OFS_DROP_RATE_B = 12'h008;
  localparam logic [11:0] OFS_ING_RATES   = 12'h00c;
  localparam logic [11:0] OFS_WFQ_WEIGHTS = 12'h010;
  localparam logic [11:0] OFS_SHAPER      = 12'h014;
  localparam logic [11:0] OFS_THR_BASE    = 12'h020;
  localparam logic [11:0] OFS_STATUS      = 12'h040;
  localparam logic [11:0] OFS_RAM_BASE    = 12'h100;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_WFQ_BIT    = 0;
  localparam int CTRL_FC_LSB     = 4;
  localparam int REC_BYTES_LSB   = 0;
  localparam int REC_BURST_LSB   = 16;
  localparam int REC_IVAL_LSB    = 32;
  localparam int REC_IVAL_UNIT   = 40;
  localparam int SHP_EN_LSB      = 28;
  localparam logic [31:0] RST_CTRL    = 32'h0000_0000;
  localparam logic [31:0] RST_WEIGHTS = 32'h1010_1010;
  localparam logic [6:0]  WFQ_TOTAL   = 7'h40;
  localparam logic [6:0]  SHP_FULL    = 7'h40;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ      = 25;
  localparam int TICK_FINE_NS = 10000;
  localparam int TICK_FINE_CY = TICK_FINE_NS * CLK_MHZ / 1000;
  localparam int TICK_MS_CY   = 100;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic       valid;
    logic [1:0] port;
    logic [1:0] queue;
    logic [12:0] len;
  } qsr_tx_s;

  typedef struct packed
  {
    logic       valid;
    logic [1:0] port;
    logic       high_drop;
    logic [12:0] len;
  } qsr_rx_s;

  typedef enum logic [1:0]
  {
    RV_IDLE  = 2'b00,
    RV_CHECK = 2'b01,
    RV_ANS   = 2'b10
  } qsr_rv_e;

endpackage

// ---- qsr_top.sv ----
/*
  QoS scheduler, WRED and fast-port rate control behind an APB slave.
  Assumes queue status and frames arrive from the frame engine on pclk,
  and that buffer_manager reject is a same-clock input.
*/
`timescale 1ns/1ps
`default_nettype none

module qsr_top
  import qsr_pkg::*;
#(
  parameter int NFAST = 4
)
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               clk_en,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [2*NFAST-1:0] fast_q_nonempty,
  input  wire logic [3:0]         up_q_nonempty,
  input  wire logic [3:0]         cpu_q_nonempty,
  input  wire logic [16*NFAST-1:0] fast_qbytes,
  input  wire logic [47:0]        up_qbytes,
  input  wire logic               mac_idle_up,
  input  wire qsr_tx_s            tx_done,
  input  wire qsr_rx_s            rx_frame,
  input  wire logic               enq_valid,
  input  wire logic               enq_uplink,
  input  wire logic [1:0]         enq_port,
  input  wire logic [1:0]         enq_queue,
  input  wire logic               enq_high_drop,
  input  wire logic               bm_reject,
  output logic      [NFAST-1:0]   fast_sel_hi,
  output logic      [NFAST-1:0]   fast_tx_ok,
  output logic      [1:0]         up_sel,
  output logic                    up_sel_valid,
  output logic      [1:0]         cpu_sel,
  output logic                    enq_drop,
  output logic                    rx_drop,
  output logic      [NFAST-1:0]   pause_req
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_ff, rate_a_ff, rate_b_ff, ing_rates_ff;
  logic [31:0] weights_ff, shaper_ff;
  logic [31:0] thr_ff [8];
  logic [63:0] rc_ram [NFAST];
  logic [31:0] drop_cnt_ff;
  logic [7:0]  lfsr_ff;
  logic [15:0] credit_ff [NFAST];
  logic [7:0]  ival_cnt_ff [NFAST];
  logic [11:0] tick_cnt_ff;
  logic [6:0]  ms_cnt_ff;
  logic [6:0]  wfq_cred_ff [4];
  logic [6:0]  shp_acc_ff [4];

  wire wr_en = clk_en && psel && penable && pwrite;
  wire in_thr = paddr[11:5] == OFS_THR_BASE[11:5];
  wire in_ram = paddr[11:8] == OFS_RAM_BASE[11:8]
                && paddr[7:3] < 5'(NFAST);
  wire known  = in_thr || in_ram || paddr == OFS_CTRL
                || paddr == OFS_DROP_RATE_A || paddr == OFS_DROP_RATE_B
                || paddr == OFS_ING_RATES || paddr == OFS_WFQ_WEIGHTS
                || paddr == OFS_SHAPER || paddr == OFS_STATUS;
  wire [1:0] ram_idx = paddr[4:3];
  wire       ram_hi  = paddr[2];

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !known;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_ff      <= RST_CTRL;
      rate_a_ff    <= 32'h0;
      rate_b_ff    <= 32'h0;
      ing_rates_ff <= 32'h0;
      weights_ff   <= RST_WEIGHTS;
      shaper_ff    <= 32'h0;
    end
    else if (wr_en)
    begin
      if (paddr == OFS_CTRL) ctrl_ff <= pwdata;
      if (paddr == OFS_DROP_RATE_A) rate_a_ff <= pwdata;
      if (paddr == OFS_DROP_RATE_B) rate_b_ff <= pwdata;
      if (paddr == OFS_ING_RATES) ing_rates_ff <= pwdata;
      if (paddr == OFS_WFQ_WEIGHTS) weights_ff <= pwdata;
      if (paddr == OFS_SHAPER) shaper_ff <= pwdata;
    end
  end

  // Thresholds: no reset, software loads them before traffic
  always_ff @(posedge pclk)
  begin
    if (wr_en && in_thr)
      thr_ff[paddr[4:2]] <= pwdata;
  end

  // Rate records clear so credit starts from a known zero limit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NFAST; i++)
        rc_ram[i] <= 64'h0;
    end
    else
    begin
      if (wr_en && in_ram && !ram_hi)
        rc_ram[ram_idx][31:0] <= pwdata;
      if (wr_en && in_ram && ram_hi)
        rc_ram[ram_idx][63:32] <= {24'h0, pwdata[7:0]};
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0;
    case (paddr)
      OFS_CTRL:        rd_mux = ctrl_ff;
      OFS_DROP_RATE_A: rd_mux = rate_a_ff;
      OFS_DROP_RATE_B: rd_mux = rate_b_ff;
      OFS_ING_RATES:   rd_mux = ing_rates_ff;
      OFS_WFQ_WEIGHTS: rd_mux = weights_ff;
      OFS_SHAPER:      rd_mux = shaper_ff;
      OFS_STATUS:      rd_mux = drop_cnt_ff;
      default:
      begin
        if (in_thr)
          rd_mux = thr_ff[paddr[4:2]];
        else if (in_ram)
          rd_mux = ram_hi ? rc_ram[ram_idx][63:32] : rc_ram[ram_idx][31:0];
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (clk_en && psel && !penable && !pwrite)
      prdata <= rd_mux;
  end

  // ----------------------------------------------------------------
  // Strict priority: fast ports and CPU
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NFAST; g++)
    begin : g_fast
      // Two queues per fast port, high wins when it holds a frame
      assign fast_sel_hi[g] = fast_q_nonempty[2*g+1];
      assign fast_tx_ok[g]  = credit_ff[g] != 16'h0;
    end
  endgenerate

  function automatic logic [1:0] sp_pick(input logic [3:0] ne);
    logic [1:0] r;
    r = 2'd0;
    if (ne[3]) r = 2'd3;
    else if (ne[2]) r = 2'd2;
    else if (ne[1]) r = 2'd1;
    return r;
  endfunction

  assign cpu_sel = sp_pick(cpu_q_nonempty);

  // ----------------------------------------------------------------
  // Uplink: shapers, strict priority or WFQ
  // ----------------------------------------------------------------
  logic [3:0] shp_en, shp_ok, wfq_ok;
  generate
    for (g = 0; g < 4; g++)
    begin : g_up
      assign shp_en[g] = shaper_ff[SHP_EN_LSB+g];
      assign shp_ok[g] = up_q_nonempty[g] && shp_en[g]
                         && shp_acc_ff[g] >= SHP_FULL;
      assign wfq_ok[g] = up_q_nonempty[g] && !shp_en[g]
                         && wfq_cred_ff[g] != 7'h0;
    end
  endgenerate

  wire        wfq_mode = ctrl_ff[CTRL_WFQ_BIT];
  wire [3:0]  sp_cand  = wfq_mode ? 4'h0 : up_q_nonempty & ~shp_en;
  wire [3:0]  any_ok   = shp_ok | sp_cand;
  wire [1:0]  wfq_idx  = sp_pick(wfq_ok);
  assign up_sel       = (any_ok != 4'h0) ? sp_pick(any_ok) : wfq_idx;
  assign up_sel_valid = (any_ok != 4'h0) || (wfq_ok != 4'h0);

  // Shaper accumulators: add setting each cycle while below full, clear to zero on tx
  wire up_done = tx_done.valid && tx_done.port == 2'd3;
  generate
    for (g = 0; g < 4; g++)
    begin : g_shp
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          shp_acc_ff[g] <= 7'h0;
        else if (clk_en)
        begin
          if (up_done && tx_done.queue == 2'(g))
            shp_acc_ff[g] <= 7'h0;
          else if (shp_acc_ff[g] < SHP_FULL)
            shp_acc_ff[g] <= shp_acc_ff[g] + shaper_ff[7*g +: 7];
        end
      end
    end
  endgenerate

  // WFQ credits: reload with the weights when no unshaped queue has both a frame and credit
  wire wfq_reload = wfq_ok == 4'h0 || mac_idle_up;
  generate
    for (g = 0; g < 4; g++)
    begin : g_wfq
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          wfq_cred_ff[g] <= 7'h0;
        else if (clk_en)
        begin
          if (wfq_reload && wfq_ok == 4'h0)
            // Seven bits: one queue may hold the whole weight of 64
            wfq_cred_ff[g] <= weights_ff[8*g +: 7];
          else if (up_done && tx_done.queue == 2'(g) && wfq_cred_ff[g] != 0)
            wfq_cred_ff[g] <= wfq_cred_ff[g] - 7'h1;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // WRED on enqueue
  // ----------------------------------------------------------------
  wire [15:0] qb = enq_uplink ? up_qbytes[16*(enq_queue-2'd1) +: 16]
                              : fast_qbytes[16*enq_port +: 16];
  wire [2:0]  tix = enq_uplink ? {1'b1, enq_queue} : {1'b0, enq_port};
  wire        wred_q = enq_uplink ? enq_queue != 2'd0
                                  : enq_queue == 2'd1;
  wire        over1 = qb > thr_ff[tix][15:0];
  wire        over2 = qb > thr_ff[tix][31:16];
  wire [7:0]  rnd = {1'b0, lfsr_ff[6:0]};
  wire hit_x = rnd < rate_a_ff[7:0];
  wire hit_y = rnd < rate_a_ff[15:8];
  wire hit_z = rnd < rate_b_ff[7:0];
  logic wred_drop;
  always_comb
  begin
    wred_drop = 1'b0;
    if (wred_q && over2)
      wred_drop = enq_high_drop ? 1'b1 : hit_z;
    else if (wred_q && over1)
      wred_drop = enq_high_drop ? hit_x : hit_y;
  end
  // Applies in both strict and WFQ modes
  assign enq_drop = enq_valid && (bm_reject || wred_drop);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lfsr_ff     <= 8'h5a;
      drop_cnt_ff <= 32'h0;
    end
    else if (clk_en)
    begin
      lfsr_ff <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4]
                  ^ lfsr_ff[3]};
      if (enq_drop || rx_drop)
        drop_cnt_ff <= drop_cnt_ff + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Fast-port rate control
  // ----------------------------------------------------------------
  wire tick_fine = tick_cnt_ff == 12'(TICK_FINE_CY - 1);
  wire tick_ms   = tick_fine && ms_cnt_ff == 7'(TICK_MS_CY - 1);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt_ff <= 12'h0;
      ms_cnt_ff   <= 7'h0;
    end
    else if (clk_en)
    begin
      tick_cnt_ff <= tick_fine ? 12'h0 : tick_cnt_ff + 12'h1;
      if (tick_fine)
        ms_cnt_ff <= tick_ms ? 7'h0 : ms_cnt_ff + 7'h1;
    end
  end

  logic [NFAST-1:0] rx_drop_v;
  generate
    for (g = 0; g < NFAST; g++)
    begin : g_rc
      wire [63:0] rec   = rc_ram[g];
      wire [15:0] allow = rec[REC_BYTES_LSB +: 16];
      wire [15:0] burst = rec[REC_BURST_LSB +: 16];
      wire [7:0]  ival  = rec[REC_IVAL_LSB +: 8];
      wire        unit  = ctrl_ff[REC_IVAL_UNIT-32+g];
      wire        tk    = unit ? tick_ms : tick_fine;
      wire        bound = tk && ival_cnt_ff[g] + 8'h1 >= ival;
      wire        txp   = tx_done.valid && tx_done.port == 2'(g);
      wire        rxp   = rx_frame.valid && rx_frame.port == 2'(g);
      wire [15:0] cost  = 16'((txp ? tx_done.len + 13'h7 : 13'h0) >> 3)
                        + 16'((rxp ? rx_frame.len + 13'h7 : 13'h0) >> 3);
      wire [16:0] gain  = {1'b0, credit_ff[g]} + (bound ? {1'b0, allow}
                                                        : 17'h0);
      wire [16:0] capd  = gain > {1'b0, burst} ? {1'b0, burst} : gain;
      wire [15:0] nxt_credit = capd > {1'b0, cost}
                               ? 16'(capd - {1'b0, cost}) : 16'h0;
      wire        fc_on = ctrl_ff[CTRL_FC_LSB+g];
      wire        none  = credit_ff[g] == 16'h0;
      wire        qtr   = credit_ff[g] <= (burst >> 2);
      wire        half  = credit_ff[g] <= (burst >> 1);
      logic       drp;
      always_comb
      begin
        drp = 1'b0;
        if (!fc_on && none)
          drp = 1'b1;
        else if (!fc_on && qtr)
          drp = rx_frame.high_drop ? 1'b1
                : rnd < ing_rates_ff[7:0];
        else if (!fc_on && half)
          drp = rx_frame.high_drop && rnd < ing_rates_ff[15:8];
      end
      assign rx_drop_v[g] = rxp && drp;

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          credit_ff[g]   <= 16'h0;
          ival_cnt_ff[g] <= 8'h0;
          pause_req[g]   <= 1'b0;
        end
        else if (clk_en)
        begin
          credit_ff[g] <= nxt_credit;
          if (tk)
            ival_cnt_ff[g] <= bound ? 8'h0 : ival_cnt_ff[g] + 8'h1;
          pause_req[g] <= fc_on && (nxt_credit < (burst >> 1));
        end
      end
    end
  endgenerate

  assign rx_drop = |rx_drop_v;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_up_strict: assert property (
    !wfq_mode && shp_en == 4'h0 && up_q_nonempty[3] |-> up_sel == 2'd3)
    else $error("uplink high queue not served first");
  chk_cpu_order: assert property (
    cpu_q_nonempty[1] && !cpu_q_nonempty[3] && !cpu_q_nonempty[2]
    |-> cpu_sel == 2'd1)
    else $error("cpu lower queue served before higher");
  chk_bm_drop: assert property (
    enq_valid && bm_reject |-> enq_drop)
    else $error("buffer reject did not drop");
  chk_no_be_wred: assert property (
    enq_valid && enq_uplink && enq_queue == 2'd0 && !bm_reject
    |-> !enq_drop)
    else $error("best effort dropped by wred");
  chk_l2_high: assert property (
    enq_valid && wred_q && over2 && enq_high_drop |-> enq_drop)
    else $error("high drop over level two kept");
  chk_cap_burst: assert property (
    clk_en |=> credit_ff[0] <= $past(rc_ram[0][31:16]))
    else $error("credit above burst limit");
  chk_nocredit: assert property (
    rx_frame.valid && rx_frame.port == 2'd0 && !ctrl_ff[CTRL_FC_LSB]
    && credit_ff[0] == 16'h0 |-> rx_drop)
    else $error("frame kept with no credit");
  chk_pause: assert property (
    clk_en && ctrl_ff[CTRL_FC_LSB] && credit_ff[0] == 16'h0
    && rc_ram[0][31:16] > 16'h1 && !rx_frame.valid && !tick_fine
    ##1 clk_en |-> pause_req[0])
    else $error("pause missing at low credit");

endmodule

`default_nettype wire

// ---- qsr_far_side.sv ----
/*
  Far-side model: frame engine queue status and fast-port transmit MAC.
  Assumes the bench calls its tasks from one process, synchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none

module qsr_far_side
  import qsr_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic [3:0]  fast_tx_ok,
  output logic      [7:0]  fast_q_nonempty,
  output logic      [3:0]  up_q_nonempty,
  output logic      [3:0]  cpu_q_nonempty,
  output logic      [63:0] fast_qbytes,
  output logic      [47:0] up_qbytes,
  output logic             mac_idle_up,
  output qsr_tx_s          tx_done
);
  initial
  begin
    fast_q_nonempty = 8'h00;
    up_q_nonempty = 4'h0;
    cpu_q_nonempty = 4'h0;
    fast_qbytes = 64'h0;
    up_qbytes = 48'h0;
    mac_idle_up = 1'b1;
    tx_done = '0;
  end

  // ----------------------------------------------------------------
  // Queue status
  // ----------------------------------------------------------------
  task automatic set_q(input logic [7:0] f, input logic [3:0] u,
                       input logic [3:0] c, input logic [15:0] b);
    @(posedge pclk);
    fast_q_nonempty <= f;
    up_q_nonempty <= u;
    cpu_q_nonempty <= c;
    fast_qbytes <= {48'h0, b};
    up_qbytes <= {3{b}};
  endtask

  // ----------------------------------------------------------------
  // Transmit one frame only while credit allows
  // ----------------------------------------------------------------
  task automatic send_tx(input logic [1:0] p, input logic [12:0] len,
                         output logic ok);
    @(posedge pclk);
    ok = fast_tx_ok[p];
    if (ok)
      tx_done <= '{1'b1, p, 2'h1, len};
    @(posedge pclk);
    tx_done <= '0;
  endtask
endmodule

`default_nettype wire

// ---- switch_qos_scheduler_rate_control_test.sv ----
/*
  Self-checking bench: APB register access, scheduling, drop and credit.
  Assumes qsr_top with four fast ports and zero-wait APB answers.
*/
`timescale 1ns/1ps
`default_nettype none

module switch_qos_scheduler_rate_control_test;
  import qsr_pkg::*;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready;
  logic        pslverr, enq_valid, enq_high_drop, bm_reject, mac_idle_up;
  logic        up_sel_valid, enq_drop, rx_drop, ok, err, enq_uplink;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0]  fast_q_nonempty;
  logic [3:0]  up_q_nonempty, cpu_q_nonempty, fast_sel_hi, fast_tx_ok;
  logic [3:0]  pause_req;
  logic [63:0] fast_qbytes;
  logic [47:0] up_qbytes;
  logic [1:0]  up_sel, cpu_sel, enq_queue;
  qsr_tx_s     tx_done;
  qsr_rx_s     rx_frame;
  int          n_mismatch, samples_checked, n;

  qsr_top #(.NFAST(4)) i_qsr_top (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fast_q_nonempty(fast_q_nonempty),
    .up_q_nonempty(up_q_nonempty), .cpu_q_nonempty(cpu_q_nonempty),
    .fast_qbytes(fast_qbytes), .up_qbytes(up_qbytes),
    .mac_idle_up(mac_idle_up), .tx_done(tx_done), .rx_frame(rx_frame),
    .enq_valid(enq_valid), .enq_uplink(enq_uplink), .enq_port(2'h0),
    .enq_queue(enq_queue), .enq_high_drop(enq_high_drop),
    .bm_reject(bm_reject),
    .fast_sel_hi(fast_sel_hi), .fast_tx_ok(fast_tx_ok), .up_sel(up_sel),
    .up_sel_valid(up_sel_valid), .cpu_sel(cpu_sel), .enq_drop(enq_drop),
    .rx_drop(rx_drop), .pause_req(pause_req));

  qsr_far_side i_qsr_far_side (.pclk(pclk), .fast_tx_ok(fast_tx_ok),
    .fast_q_nonempty(fast_q_nonempty), .up_q_nonempty(up_q_nonempty),
    .cpu_q_nonempty(cpu_q_nonempty), .fast_qbytes(fast_qbytes),
    .up_qbytes(up_qbytes), .mac_idle_up(mac_idle_up), .tx_done(tx_done));

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check("read data", e, q);
  endtask

  task automatic enq(input logic [15:0] b, input logic hd, input logic bm,
                     input logic e);
    i_qsr_far_side.set_q(8'h02, 4'h0, 4'h0, b);
    enq_valid <= 1'b1;
    enq_high_drop <= hd;
    bm_reject <= bm;
    @(negedge pclk);
    check("enq_drop", 32'(e), 32'(enq_drop));
    @(posedge pclk);
    enq_valid <= 1'b0;
    bm_reject <= 1'b0;
  endtask

  task automatic rx(input logic [12:0] len, input logic hd);
    @(posedge pclk);
    rx_frame <= '{1'b1, 2'h0, hd, len};
    @(negedge pclk);
    q = 32'(rx_drop);
    @(posedge pclk);
    rx_frame <= '0;
  endtask

  function automatic logic [1:0] top_q(input logic [3:0] v);
    top_q = v[3] ? 2'h3 : v[2] ? 2'h2 : v[1] ? 2'h1 : 2'h0;
  endfunction

  initial
  begin
    repeat (60000) @(posedge pclk);
    n_mismatch++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    presetn = 1'b0;
    clk_en = 1'b1;
    {psel, penable, pwrite, enq_valid, enq_high_drop, bm_reject} = 6'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    rx_frame = '0;
    enq_uplink = 1'b0;
    enq_queue = 2'h1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_CTRL, RST_CTRL);
    rd(OFS_WFQ_WEIGHTS, RST_WEIGHTS);
    apb(1'b1, OFS_WFQ_WEIGHTS, 32'h2808_0808);
    rd(OFS_WFQ_WEIGHTS, 32'h2808_0808);
    clk_en <= 1'b0;
    apb(1'b1, OFS_DROP_RATE_B, 32'h0000_0055);
    clk_en <= 1'b1;
    rd(OFS_DROP_RATE_B, 32'h0);
    apb(1'b0, 12'hffc, 32'h0);
    check("unmapped error", 32'h1, 32'(err));
    check("unmapped read", 32'h0, q);
    $display("test registers done");

    for (int i = 1; i < 16; i++)
    begin
      i_qsr_far_side.set_q({4{i[1:0]}}, i[3:0], i[3:0], 16'h0);
      @(negedge pclk);
      check("up_sel", 32'(top_q(i[3:0])), 32'(up_sel));
      check("up_sel_valid", 32'h1, 32'(up_sel_valid));
      check("cpu_sel", 32'(top_q(i[3:0])), 32'(cpu_sel));
      if (i[1:0] != 2'h0)
        check("fast_sel_hi", {28'h0, {4{i[1]}}}, 32'(fast_sel_hi));
    end
    apb(1'b1, OFS_SHAPER, 32'h8000_0000);
    @(negedge pclk);
    check("shaped queue held", 32'h2, 32'(up_sel));
    apb(1'b1, OFS_SHAPER, 32'h8800_0000);
    @(posedge pclk);
    @(negedge pclk);
    check("shaped queue sent", 32'h3, 32'(up_sel));
    apb(1'b1, OFS_SHAPER, 32'h0);
    apb(1'b1, OFS_WFQ_WEIGHTS, 32'h0010_2010);
    i_qsr_far_side.set_q(8'h00, 4'h0, 4'h0, 16'h0);
    i_qsr_far_side.set_q(8'h00, 4'hf, 4'hf, 16'h0);
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    @(negedge pclk);
    check("wfq up_sel", 32'h2, 32'(up_sel));
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    $display("test strict priority done");

    apb(1'b1, OFS_THR_BASE, 32'h0200_0100);
    apb(1'b1, OFS_THR_BASE + 12'h01c, 32'h0200_0100);
    apb(1'b1, OFS_DROP_RATE_A, 32'h0000_8000);
    apb(1'b1, OFS_DROP_RATE_B, 32'h0000_0000);
    enq(16'h0080, 1'b1, 1'b0, 1'b0);
    enq(16'h0180, 1'b1, 1'b0, 1'b0);
    enq(16'h0180, 1'b0, 1'b0, 1'b1);
    enq(16'h0300, 1'b1, 1'b0, 1'b1);
    enq(16'h0300, 1'b0, 1'b0, 1'b0);
    enq(16'h0080, 1'b0, 1'b1, 1'b1);
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    enq(16'h0300, 1'b1, 1'b0, 1'b1);
    enq_uplink <= 1'b1;
    enq_queue <= 2'h0;
    enq(16'h0300, 1'b1, 1'b0, 1'b0);
    enq_queue <= 2'h3;
    enq(16'h0300, 1'b1, 1'b0, 1'b1);
    enq_uplink <= 1'b0;
    enq_queue <= 2'h1;
    rd(OFS_STATUS, 32'h0000_0005);
    $display("test drop rules done");

    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    apb(1'b1, OFS_RAM_BASE + 12'h004, 32'hffff_ff01);
    apb(1'b1, OFS_RAM_BASE, 32'h0064_0000);
    rd(OFS_RAM_BASE + 12'h004, 32'h0000_0001);
    rd(OFS_RAM_BASE, 32'h0064_0000);
    rx(13'd64, 1'b0);
    check("rx_drop", 32'h1, q);
    i_qsr_far_side.send_tx(2'h0, 13'd64, ok);
    check("tx held", 32'h0, 32'(ok));
    apb(1'b1, OFS_CTRL, 32'h0000_0010);
    repeat (4) @(negedge pclk);
    check("pause on", 32'h1, 32'(pause_req[0]));
    apb(1'b1, OFS_RAM_BASE, 32'h0064_0004);
    n = 0;
    while (pause_req[0] !== 1'b0 && n < 5000)
    begin
      @(negedge pclk);
      n++;
    end
    check("pause off", 32'h0, 32'(pause_req[0]));
    repeat (4000) @(posedge pclk);
    i_qsr_far_side.send_tx(2'h0, 13'd8, ok);
    check("tx sent", 32'h1, 32'(ok));
    rx(13'd480, 1'b0);
    repeat (3) @(negedge pclk);
    check("pause after burst", 32'h1, 32'(pause_req[0]));
    apb(1'b1, OFS_ING_RATES, 32'h0000_8000);
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    rx(13'd64, 1'b1);
    check("rx_drop half credit", 32'h1, q);
    $display("test rate control done");
    stop_test();
  end
endmodule

`default_nettype wire
